// File: ddr_gear_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_gear_asserts (
	input wire logic       clk_in, reset_in, fifo_bypass_in, word_align_request_in, word_ready_in,
	input wire logic [6:0] word_out,
	input wire logic       word_valid_out, slow_tick_out,
	input wire logic [2:0] fifo_read_pointer_out, fifo_write_pointer_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (reset_in);
	chk_reset_clear: assert property (disable iff (1'b0)
		reset_in |-> word_out == 7'h00 && !word_valid_out) else $error("outputs not clear in reset");
	chk_word_stands: assert property (
		word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_out)) else $error("word dropped");
	chk_tick_loads: assert property (
		slow_tick_out |=> word_valid_out) else $error("update did not reach buffer");
	chk_valid_cause: assert property (
		$rose(word_valid_out) |-> $past(slow_tick_out)) else $error("word without update");
	chk_tick_pulse: assert property (
		slow_tick_out |=> !slow_tick_out) else $error("tick longer than one cycle");
	chk_wptr_step: assert property (
		$changed(fifo_write_pointer_out) |-> fifo_write_pointer_out == 3'($past(fifo_write_pointer_out) + 3'h1))
		else $error("write pointer jumped");
	chk_rptr_step: assert property (
		$changed(fifo_read_pointer_out) |-> fifo_read_pointer_out == 3'($past(fifo_read_pointer_out) + 3'h1))
		else $error("read pointer jumped");
	chk_bypass_freeze: assert property (
		fifo_bypass_in [*8] |=> $stable(fifo_write_pointer_out)) else $error("fifo written in bypass");
	cover property (slow_tick_out);
	cover property (word_valid_out && !word_ready_in);
	cover property ($rose(word_align_request_in));
	cover property ($changed(fifo_read_pointer_out));
endmodule // ddr_gear_asserts
bind ddr_input_gearing_fifo ddr_gear_asserts ddr_gear_asserts_i (.clk_in(clk_in), .reset_in(reset_in),
	.fifo_bypass_in(fifo_bypass_in), .word_align_request_in(word_align_request_in),
	.word_ready_in(word_ready_in), .word_out(word_out), .word_valid_out(word_valid_out),
	.slow_tick_out(slow_tick_out), .fifo_read_pointer_out(fifo_read_pointer_out),
	.fifo_write_pointer_out(fifo_write_pointer_out));
`default_nettype wire

// File: ddr_in_gear_defines.vh
`ifndef DDR_IN_GEAR_DEFINES_VH
`define DDR_IN_GEAR_DEFINES_VH
`define MODE_SINGLE     2'h0
`define MODE_DOUBLE     2'h1
`define MODE_SEVEN      2'h2
`define PTR_W           3
`define FIFO_DEPTH      8
`define WORD_W          7
`define SHIFT_W         14
`define DELAY_MAX_W     4
`define MEM_PERIOD_NS   160
`define CLK_PERIOD_NS   10
`define QUARTER_CYCLES  ((`MEM_PERIOD_NS / 4) / `CLK_PERIOD_NS)
`endif

// File: ddr_input_gearing_fifo.v
`timescale 1ns/100ps
`default_nettype none
`include "ddr_in_gear_defines.vh"
module ddr_input_gearing_fifo #(
	parameter TOP_SIDE = 0
) (
	// clock and reset
	input  wire       clk_in,
	input  wire       reset_in,
	// pins from far side
	input  wire       pin_data_in,
	input  wire       fast_edge_clock_in,
	input  wire       read_strobe_in,
	// core control
	input  wire [1:0] gear_mode_in,
	input  wire [3:0] input_delay_in,
	input  wire       fifo_bypass_in,
	input  wire       word_align_request_in,
	// core data
	output reg  [6:0] word_out,
	output wire       word_valid_out,
	input  wire       word_ready_in,
	output wire [2:0] fifo_read_pointer_out,
	output wire [2:0] fifo_write_pointer_out,
	output wire       slow_tick_out
);
	// all pins pass two flops before any logic
	reg [1:0] pin_s_reg;
	reg [1:0] ecl_s_reg;
	reg [1:0] dqs_s_reg;
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			pin_s_reg <= 2'h0;
			ecl_s_reg <= 2'h0;
			dqs_s_reg <= 2'h0;
		end else begin
			pin_s_reg <= {pin_s_reg[0], pin_data_in};
			ecl_s_reg <= {ecl_s_reg[0], fast_edge_clock_in};
			dqs_s_reg <= {dqs_s_reg[0], read_strobe_in};
		end
	end
	reg ecl_d_reg;
	reg dqs_d_reg;
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ecl_d_reg <= 1'b0;
			dqs_d_reg <= 1'b0;
		end else begin
			ecl_d_reg <= ecl_s_reg[1];
			dqs_d_reg <= dqs_s_reg[1];
		end
	end

	// a pin already high at release would look like an edge, so edges are
	// ignored until both sync stages and the delay flop hold the pin
	reg [1:0] warm_reg;
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			warm_reg <= 2'h0;
		else if (warm_reg != 2'h3)
			warm_reg <= warm_reg + 2'h1;
	end
	wire edges_live = (warm_reg == 2'h3);
	wire ecl_edge   = edges_live && (ecl_s_reg[1] ^ ecl_d_reg);
	wire dqs_edge   = edges_live && (dqs_s_reg[1] ^ dqs_d_reg);
	// programmable delay line on the data pin
	reg [15:0] dly_line_reg;
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			dly_line_reg <= 16'h0000;
		else
			dly_line_reg <= {dly_line_reg[14:0], pin_s_reg[1]};
	end
	// taps near a whole bit period move the sample into the previous bit
	wire pin_delayed = dly_line_reg[input_delay_in];
	// strobe edges fire the write a quarter memory period later
	reg [`QUARTER_CYCLES:0] strobe_dly_reg;
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			strobe_dly_reg <= {(`QUARTER_CYCLES + 1){1'b0}};
		else
			strobe_dly_reg <= {strobe_dly_reg[`QUARTER_CYCLES - 1:0], dqs_edge};
	end
	wire dqs_shifted = strobe_dly_reg[`QUARTER_CYCLES];

	// the strobe edge marks a bit transition; writing a quarter period later
	// samples the pin mid-eye at tap 0, and the data is written through the input_delay_in tap of the delay line
	integer k;
	// the read side trails the edge clock by two cycles so that an edge clock
	// in phase with the delayed strobe never reads an entry not yet written
	reg [1:0] ecl_late_reg;
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			ecl_late_reg <= 2'h0;
		else
			ecl_late_reg <= {ecl_late_reg[0], ecl_edge};
	end
	wire ecl_late = ecl_late_reg[1];

	// pointers kept in this cell from the delayed strobe and the late edge clock, one fifo per pin
	// no full guard: a burst longer than the depth overwrites unread bits
	reg [`PTR_W-1:0] wr_ptr_reg;
	reg [`PTR_W-1:0] rd_ptr_reg;
	reg              fifo_mem [0:`FIFO_DEPTH-1];
	wire             fifo_empty = (wr_ptr_reg == rd_ptr_reg);
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			wr_ptr_reg <= 3'h0;
			rd_ptr_reg <= 3'h0;
			for (k = 0; k < `FIFO_DEPTH; k = k + 1)
				fifo_mem[k] <= 1'b0;
		end else begin
			if (dqs_shifted && !fifo_bypass_in) begin
				fifo_mem[wr_ptr_reg] <= pin_delayed;
				wr_ptr_reg <= wr_ptr_reg + 3'h1;
			end
			if (ecl_late && !fifo_empty && !fifo_bypass_in)
				rd_ptr_reg <= rd_ptr_reg + 3'h1;
		end
	end
	assign fifo_write_pointer_out = wr_ptr_reg;
	assign fifo_read_pointer_out  = rd_ptr_reg;
	// fifo sits ahead of the gearing; bypass feeds the pin straight in
	wire gear_bit = fifo_bypass_in ? pin_delayed : fifo_mem[rd_ptr_reg];
	// top cells fall back to single rate whatever is requested
	wire [1:0] mode = (TOP_SIDE != 0) ? `MODE_SINGLE : gear_mode_in;
	reg  [3:0] word_bits;
	always @* begin
		case (mode)
		`MODE_SEVEN:  word_bits = 4'h7;
		`MODE_DOUBLE: word_bits = 4'h4;
		`MODE_SINGLE: word_bits = 4'h2;
		default:      word_bits = 4'h2;
		endcase
	end

	// stage one: shift on every edge of the fast clock in bypass, on each fifo read otherwise
	reg [`SHIFT_W-1:0] shift_reg;
	reg [3:0]          cnt_reg;
	reg [2:0]          slip_reg;
	reg                align_d_reg;
	reg [6:0]          update_reg;
	reg                update_pend_reg;
	wire               align_rise = word_align_request_in & ~align_d_reg;
	wire [3:0]         cnt_next = cnt_reg + 4'h1;
	// through the fifo a bit is shifted only once the read side holds one
	wire               shift_en = fifo_bypass_in ? ecl_edge : (ecl_late && !fifo_empty);
	wire               word_done = shift_en && (cnt_next >= word_bits);
	// the word is taken as its last bit shifts in, hence the next value
	wire [`SHIFT_W-1:0] shift_next = {shift_reg[`SHIFT_W-2:0], gear_bit};
	// stage two picks a window offset by the slip count
	wire [`SHIFT_W-1:0] shifted = shift_next >> slip_reg;
	reg  [6:0]          aligned;
	always @* begin
		aligned = 7'h00;
		case (mode)
		`MODE_SINGLE: aligned = {5'h00, shifted[1:0]};
		`MODE_DOUBLE: aligned = {3'h0, shifted[3:0]};
		`MODE_SEVEN:  aligned = shifted[6:0];
		default:      aligned = {5'h00, shifted[1:0]};
		endcase
	end

	// stage one register: the deserialising shifter and its bit count
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			shift_reg <= 14'h0000;
			cnt_reg   <= 4'h0;
		end else if (shift_en) begin
			shift_reg <= shift_next;
			cnt_reg   <= word_done ? 4'h0 : cnt_next;
		end
	end

	// stage two register: alignment slip and the update word
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			slip_reg        <= 3'h0;
			align_d_reg     <= 1'b0;
			update_reg      <= 7'h00;
			update_pend_reg <= 1'b0;
		end else begin
			align_d_reg <= word_align_request_in;
			// each request slips the word boundary by one bit
			if (align_rise)
				slip_reg <= (slip_reg + 3'h1 >= word_bits[2:0] && mode != `MODE_SEVEN) ||
				            (slip_reg == 3'h6) ? 3'h0 : slip_reg + 3'h1;
			if (word_done) begin
				update_reg      <= aligned;
				update_pend_reg <= 1'b1;
			end else begin
				update_pend_reg <= 1'b0;
			end
		end
	end
	// slow clock tick: one per word, the transfer moment
	assign slow_tick_out = update_pend_reg;

	// stage three through a two-entry buffer; a stalled core loses any word that arrives while both entries are full
	reg [6:0] buf_reg [0:1];
	reg [1:0] buf_cnt_reg;
	reg       buf_rd_reg;
	reg       buf_wr_reg;
	wire      buf_push = update_pend_reg && (buf_cnt_reg != 2'h2);
	wire      buf_pop  = word_valid_out && word_ready_in;
	assign word_valid_out = (buf_cnt_reg != 2'h0);
	always @* word_out = buf_reg[buf_rd_reg];
	always @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			buf_reg[0]  <= 7'h00;
			buf_reg[1]  <= 7'h00;
			buf_cnt_reg <= 2'h0;
			buf_rd_reg  <= 1'b0;
			buf_wr_reg  <= 1'b0;
		end else begin
			if (buf_push) begin
				buf_reg[buf_wr_reg] <= update_reg;
				buf_wr_reg <= ~buf_wr_reg;
			end
			if (buf_pop)
				buf_rd_reg <= ~buf_rd_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end
endmodule // ddr_input_gearing_fifo
`default_nettype wire

// File: ddr_src.sv
`timescale 1ns/100ps
`default_nettype none
module ddr_src (
	output var logic pin_data_out,
	output var logic edge_clk_out,
	output var logic strobe_out
);
	initial begin
		pin_data_out = 1'b0;
		edge_clk_out = 1'b0;
		strobe_out = 1'b0;
	end
	// strobe edge-aligned with data; edge clock a quarter later, centred in the bit
	task automatic send(input logic [6:0] bits, input int n);
		#2;
		for (int i = n - 1; i >= 0; i--) begin
			pin_data_out = bits[i];
			strobe_out = ~strobe_out;
			#40 edge_clk_out = ~edge_clk_out;
			#40;
		end
		pin_data_out = ~pin_data_out; // released line must not hold its last bit
	endtask
endmodule // ddr_src
`default_nettype wire

// File: tb_ddr_input_gearing_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module tb_ddr_input_gearing_fifo;
	typedef struct packed {logic [1:0] m; logic b; logic [3:0] d; logic [2:0] n; logic [6:0] v;} row_t;
	logic       clk_in = 1'b0, reset_in = 1'b1, align = 1'b0, ready = 1'b0, bypass = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [3:0] dly = 4'h0;
	wire logic  pin, fast_edge_clock, strobe, valid, tick;
	wire logic [6:0] word;
	int         n_mismatch = 0, cmp_count = 0;
	// mode, bypass, delay taps, bit count, word sent first bit first
	row_t rows [4] = '{'{2'h0, 1'b1, 4'h0, 3'h2, 7'h01}, '{2'h1, 1'b0, 4'h2, 3'h4, 7'h0B},
		'{2'h2, 1'b1, 4'h3, 3'h7, 7'h65}, '{2'h1, 1'b1, 4'h0, 3'h4, 7'h06}};
	always #5 clk_in = ~clk_in;
	ddr_src ddr_src_i (.pin_data_out(pin), .edge_clk_out(fast_edge_clock), .strobe_out(strobe));
	ddr_input_gearing_fifo ddr_input_gearing_fifo_i (.clk_in(clk_in), .reset_in(reset_in), .pin_data_in(pin),
		.fast_edge_clock_in(fast_edge_clock), .read_strobe_in(strobe), .gear_mode_in(mode), .input_delay_in(dly),
		.fifo_bypass_in(bypass), .word_align_request_in(align), .word_out(word), .word_valid_out(valid),
		.word_ready_in(ready), .fifo_read_pointer_out(), .fifo_write_pointer_out(), .slow_tick_out(tick));
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input string what, input logic [6:0] exp, input logic [6:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic do_reset();
		@(posedge clk_in) reset_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in) #1;
	endtask
	task automatic wait_valid();
		for (int k = 0; k < 400 && valid !== 1'b1; k++) @(posedge clk_in) #1;
		if (valid !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
	endtask
	// one cycle with ready high: the word is taken at that edge
	task automatic accept();
		@(posedge clk_in) ready <= 1'b1;
		@(posedge clk_in) ready <= 1'b0;
		#1;
	endtask
	initial begin
		do_reset();
		check("word", 7'h00, word);
		check("valid", 7'h00, {6'h00, valid});
		$display("reset test done");
		foreach (rows[i]) begin
			mode <= rows[i].m;
			bypass <= rows[i].b;
			dly <= rows[i].d;
			do_reset();
			ddr_src_i.send(rows[i].v, rows[i].n);
			wait_valid();
			check("word", rows[i].v, word);
			accept();
			$display("row %0d done", i);
		end
		// stall: two words held, the third is lost while the core refuses
		mode <= 2'h1;
		bypass <= 1'b1;
		do_reset();
		ddr_src_i.send(7'h03, 4);
		ddr_src_i.send(7'h05, 4);
		ddr_src_i.send(7'h09, 4);
		wait_valid();
		check("first", 7'h03, word);
		accept();
		check("second", 7'h05, word);
		accept();
		repeat (30) @(posedge clk_in);
		#1 check("drained", 7'h00, {6'h00, valid});
		$display("stall test done");
		// one slip request moves the window one bit older: zero above 3'b101
		do_reset();
		@(posedge clk_in) align <= 1'b1;
		@(posedge clk_in) align <= 1'b0;
		ddr_src_i.send(7'h0B, 4);
		wait_valid();
		check("slipped", 7'h05, word);
		accept();
		$display("align test done");
		finish_test();
	end
endmodule // tb_ddr_input_gearing_fifo
`default_nettype wire
